// >>> hw/csc_regs.svh
// Purpose: Register offsets, field positions and reset values of the
//          conversion start control block.
// Assumes: Byte-wide register port, one register per byte offset.
// Notes:   Definitions only; included by the design files.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CSC_OFS_WRAP   8'h00
`define CSC_OFS_CFG    8'h01
`define CSC_OFS_CTL    8'h05
`define CSC_OFS_STAT   8'h06

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSC_CTL_SC     6
`define CSC_CTL_SCAN   5
`define CSC_CTL_MULTI_CHANNEL_MODE   4
`define CSC_CFG_ETRIG  4
`define CSC_STAT_SCF   7

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define CSC_CTL_RST    7'h00
`define CSC_WRAP_RST   4'hf
`define CSC_CFG_RST    5'h00
`define CSC_LEN_MAX    3'h6
`define CSC_LAST_EXT   4'h5

`endif

// >>> hw/csc_pkg.sv
// Purpose: Types shared by the conversion start control design files.
// Assumes: Nothing beyond the register header.
// Notes:   The channel descriptor travels as one packed struct.
package csc_pkg;

  // ----------------------------------------------------------------------
  // Converter input source kinds
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_EXT  = 3'h0,
    SRC_INT  = 3'h1,
    SRC_VRH  = 3'h2,
    SRC_VRL  = 3'h3,
    SRC_MID  = 3'h4,
    SRC_RSVD = 3'h5
  } csc_src_e;

  // Channel descriptor handed to the analog front end.
  typedef struct packed {
    csc_src_e    src;
    logic [2:0]  idx;
  } csc_chan_s;

  // Sequencer states, Gray coded along idle, sample, convert, armed.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11,
    ST_ARMED   = 2'b10
  } csc_state_e;

endpackage

// >>> hw/csc_trig_sync.sv
// Purpose: Synchronise the external trigger pin and detect its rise.
// Assumes: Trigger pin is asynchronous to CLOCK_I.
// Notes:   Rising edge gives a one-cycle pulse two edges later.
`timescale 1ns/1ns
module csc_trig_sync
  import csc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic trig_i,
  output logic      rise_o
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // ----------------------------------------------------------------------
  // Two-stage synchroniser and edge history
  // ----------------------------------------------------------------------
  // Only sync_ff reads meta_ff, so metastability never reaches the edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= trig_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Rise is a clean level compare of two synchronised stages.
  assign rise_o = sync_ff & ~prev_ff;

endmodule

// >>> hw/csc_chan_map.sv
// Purpose: Decode special enable and select code into a channel.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Reserved special codes decode to SRC_RSVD.
`timescale 1ns/1ns
`include "csc_regs.svh"
module csc_chan_map
  import csc_pkg::*;
(
  input  wire logic       sc_i,
  input  wire logic [3:0] code_i,
  output csc_chan_s       chan_o
);

  // ----------------------------------------------------------------------
  // Code decode
  // ----------------------------------------------------------------------
  // External codes above the last input all land on the last input.
  always_comb begin
    chan_o = '{src: SRC_RSVD, idx: 3'h0};
    if (!sc_i) begin
      chan_o.src = SRC_EXT;
      chan_o.idx = (code_i > `CSC_LAST_EXT) ? 3'h5 : code_i[2:0];
    end else begin
      unique case (code_i)
        4'h0:    chan_o = '{src: SRC_INT, idx: 3'h6};
        4'h1:    chan_o = '{src: SRC_INT, idx: 3'h7};
        4'h2:    chan_o = '{src: SRC_INT, idx: 3'h0};
        4'h3:    chan_o = '{src: SRC_INT, idx: 3'h1};
        4'h4:    chan_o = '{src: SRC_VRH, idx: 3'h0};
        4'h5:    chan_o = '{src: SRC_VRL, idx: 3'h0};
        4'h6:    chan_o = '{src: SRC_MID, idx: 3'h0};
        4'h8:    chan_o = '{src: SRC_INT, idx: 3'h2};
        4'h9:    chan_o = '{src: SRC_INT, idx: 3'h3};
        4'ha:    chan_o = '{src: SRC_INT, idx: 3'h4};
        4'hb:    chan_o = '{src: SRC_INT, idx: 3'h5};
        default: chan_o = '{src: SRC_RSVD, idx: 3'h0};
      endcase
    end
  end

endmodule

// >>> hw/csc_top.sv
// Purpose: Start and channel select sequencer for an A/D converter.
// Assumes: Byte register port on CLOCK_I; converter done pulse on CLOCK_I.
// Notes:   Trigger pin is synchronised; channel output is registered.
//
// Function
// - Each control write aborts the running sequence and starts anew.
// - With trigger enabled a control write arms, then each trigger starts.
// - A start is the cycle the sample phase begins, from write or trigger.
// - Bit 6 makes the select code address internal special channels.
// - Bit 5 chooses one sequence or back-to-back sequences.
// - With trigger enabled the repeat bit is ignored.
// - With bit 4 clear every conversion uses the selected channel.
// - With bit 4 set, channels increment from the code for the length.
// - After the wrap-point channel the next channel is input 0.
// - Starting above the wrap point, the first wrap is input 5 to 0.
// - External codes 0 to 4 select inputs 0 to 4, higher codes input 5.
// - Special codes map to internals, references and their midpoint.
// - Length codes 1 to 5 give that many conversions, others give six.
// - A control write clears the sequence complete flag unless a sequence ends in that cycle.
`timescale 1ns/1ns
`include "csc_regs.svh"
module csc_top
  import csc_pkg::*;
(
  input  wire logic       CLOCK_I,
  input  wire logic       RST_N_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       EXT_TRIG_I,
  input  wire logic       CONV_DONE_I,
  output logic            SAMPLE_START_O,
  output csc_chan_s       CHAN_O,
  output logic            SEQ_BUSY_O,
  output logic            SEQ_DONE_O
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Conversions per sequence from the length code.
  function automatic logic [2:0] len_decode(input logic [3:0] code);
    logic [2:0] len;
    len = `CSC_LEN_MAX;
    if (code != 4'h0 && code < 4'h6) begin
      len = code[2:0];
    end
    return len;
  endfunction

  // Next channel code of a multi-channel sequence.
  function automatic logic [3:0] advance(input logic [3:0] cur,
                                         input logic [3:0] wrap,
                                         input logic       sc);
    logic [3:0] nxt;
    nxt = cur + 4'h1;
    if (cur == wrap) begin
      nxt = 4'h0;
    end else if (!sc && cur >= `CSC_LAST_EXT) begin
      nxt = 4'h0;
    end
    return nxt;
  endfunction

  // ----------------------------------------------------------------------
  // Registers and wires
  // ----------------------------------------------------------------------
  logic       [6:0] ctl_ff;
  logic       [3:0] wrap_ff;
  logic       [4:0] cfg_ff;
  logic             scf_ff;
  logic       [7:0] rdata_ff;
  logic       [3:0] code_ff;
  logic       [2:0] cnt_ff;
  csc_state_e       state_ff;
  csc_chan_s        chan_ff;
  csc_state_e       nxt_state;
  logic       [3:0] nxt_code;
  logic       [2:0] nxt_cnt;
  logic             nxt_scf;
  logic       [7:0] nxt_rdata;
  logic       [6:0] nxt_ctl;
  csc_chan_s        nxt_chan;
  logic             trig_rise;

  // ----------------------------------------------------------------------
  // Address decode and mode selection
  // ----------------------------------------------------------------------
  wire        wr_ctl    = REG_WR_I && (REG_ADDR_I == `CSC_OFS_CTL);
  wire        wr_cfg    = REG_WR_I && (REG_ADDR_I == `CSC_OFS_CFG);
  wire        wr_wrap   = REG_WR_I && (REG_ADDR_I == `CSC_OFS_WRAP);
  wire        wr_stat   = REG_WR_I && (REG_ADDR_I == `CSC_OFS_STAT);
  wire        ext_en    = cfg_ff[`CSC_CFG_ETRIG];
  wire        scan_eff  = ctl_ff[`CSC_CTL_SCAN] && !ext_en;
  wire        multi_channel_mode      = ctl_ff[`CSC_CTL_MULTI_CHANNEL_MODE];
  wire        sc        = ctl_ff[`CSC_CTL_SC];
  wire  [3:0] start_code = ctl_ff[3:0];
  wire  [2:0] seq_len   = len_decode(cfg_ff[3:0]);
  wire        conv_evt  = (state_ff == ST_CONVERT) && CONV_DONE_I;
  wire        last_conv = conv_evt && (cnt_ff == seq_len - 3'h1);
  // Multi mode steps the code; single mode holds the selected channel.
  wire  [3:0] step_code = multi_channel_mode ? advance(code_ff, wrap_ff, sc)
                               : start_code;
  wire        scf_clr   = wr_ctl || (wr_stat && REG_WDATA_I[`CSC_STAT_SCF]);

  // ----------------------------------------------------------------------
  // Trigger input
  // ----------------------------------------------------------------------
  csc_trig_sync u_trig (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .trig_i  (EXT_TRIG_I),
    .rise_o  (trig_rise)
  );

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  // A control write takes priority over every state, code and count update,
  // but a last conversion in the same cycle still sets the complete flag.
  always_comb begin
    nxt_state = state_ff;
    nxt_code  = code_ff;
    nxt_cnt   = cnt_ff;
    if (wr_ctl) begin
      nxt_cnt   = 3'h0;
      nxt_code  = REG_WDATA_I[3:0];
      nxt_state = ext_en ? ST_ARMED : ST_SAMPLE;
    end else if (wr_cfg || wr_wrap) begin
      nxt_cnt   = 3'h0;
      nxt_code  = start_code;
      nxt_state = ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_IDLE;
        end
        ST_ARMED: begin
          if (trig_rise) begin
            nxt_state = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          nxt_state = ST_CONVERT;
        end
        ST_CONVERT: begin
          if (last_conv) begin
            nxt_cnt  = 3'h0;
            nxt_code = start_code;
            if (ext_en) begin
              nxt_state = ST_ARMED;
            end else if (scan_eff) begin
              nxt_state = ST_SAMPLE;
            end else begin
              nxt_state = ST_IDLE;
            end
          end else if (conv_evt) begin
            nxt_cnt   = cnt_ff + 3'h1;
            nxt_code  = step_code;
            nxt_state = ST_SAMPLE;
          end
        end
      endcase
    end
  end

  // Completion sets the flag and wins over any clear in the same cycle.
  assign nxt_scf = last_conv || (scf_ff && !scf_clr);
  assign nxt_ctl = wr_ctl ? REG_WDATA_I[6:0] : ctl_ff;

  // ----------------------------------------------------------------------
  // Channel descriptor
  // ----------------------------------------------------------------------
  // Decoded from next values so the channel is valid with the sample start.
  csc_chan_map u_map (
    .sc_i   (nxt_ctl[`CSC_CTL_SC]),
    .code_i (nxt_code),
    .chan_o (nxt_chan)
  );

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  // Unmapped offsets and idle cycles read as zero.
  always_comb begin
    nxt_rdata = 8'h00;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `CSC_OFS_CTL:  nxt_rdata = {1'b0, ctl_ff};
        `CSC_OFS_CFG:  nxt_rdata = {3'h0, cfg_ff};
        `CSC_OFS_WRAP: nxt_rdata = {4'h0, wrap_ff};
        `CSC_OFS_STAT: nxt_rdata = {scf_ff, SEQ_BUSY_O, 2'h0, 1'b0, cnt_ff};
        default:       nxt_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl_ff   <= `CSC_CTL_RST;
      cfg_ff   <= `CSC_CFG_RST;
      wrap_ff  <= `CSC_WRAP_RST;
      rdata_ff <= 8'h00;
    end else begin
      ctl_ff   <= nxt_ctl;
      cfg_ff   <= wr_cfg ? REG_WDATA_I[4:0] : cfg_ff;
      wrap_ff  <= wr_wrap ? REG_WDATA_I[3:0] : wrap_ff;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff <= ST_IDLE;
      code_ff  <= 4'h0;
      cnt_ff   <= 3'h0;
      scf_ff   <= 1'b0;
      chan_ff  <= '{src: SRC_EXT, idx: 3'h0};
    end else begin
      state_ff <= nxt_state;
      code_ff  <= nxt_code;
      cnt_ff   <= nxt_cnt;
      scf_ff   <= nxt_scf;
      chan_ff  <= nxt_chan;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign SAMPLE_START_O = (state_ff == ST_SAMPLE);
  assign SEQ_BUSY_O     = (state_ff == ST_SAMPLE) ||
                          (state_ff == ST_CONVERT);
  assign SEQ_DONE_O     = scf_ff;
  assign CHAN_O         = chan_ff;
  assign REG_RDATA_O    = rdata_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  // A plain control write leads to a sample start on the next cycle.
  a_write_restart: assert property (
    wr_ctl && !ext_en |=> SAMPLE_START_O && cnt_ff == 3'h0)
    else $error("control write did not restart the sequence");

  // With trigger enabled the write only arms.
  a_write_arms: assert property (
    wr_ctl && ext_en |=> state_ff == ST_ARMED && !SAMPLE_START_O)
    else $error("control write did not arm the trigger");

  // An armed trigger rise starts sampling.
  a_trig_start: assert property (
    state_ff == ST_ARMED && trig_rise && !REG_WR_I |=> SAMPLE_START_O)
    else $error("trigger did not start a sequence");

  // Every sample start is followed by the conversion phase.
  a_sample_phase: assert property (
    SAMPLE_START_O && !REG_WR_I |=> state_ff == ST_CONVERT)
    else $error("sample start not followed by conversion");

  // Repeat mode restarts, single mode stops, trigger mode rearms.
  a_repeat_mode: assert property (
    last_conv && !REG_WR_I |=> state_ff ==
      ($past(ext_en) ? ST_ARMED : $past(scan_eff) ? ST_SAMPLE : ST_IDLE))
    else $error("wrong state after sequence end");

  // Trigger mode never chains sequences on its own.
  a_scan_ignored: assert property (
    last_conv && ext_en && !REG_WR_I |=> !SAMPLE_START_O)
    else $error("trigger mode repeated a sequence");

  // Single-channel mode keeps the selected code.
  a_single_chan: assert property (
    conv_evt && !multi_channel_mode && !REG_WR_I |=> code_ff == $past(start_code))
    else $error("single channel mode changed channel");

  // The wrap point leads back to input 0.
  a_wrap_zero: assert property (
    conv_evt && !last_conv && multi_channel_mode && code_ff == wrap_ff && !REG_WR_I
    |=> code_ff == 4'h0)
    else $error("no wrap to input 0");

  // The conversion count stays inside the decoded length.
  a_count_bound: assert property (
    cnt_ff < seq_len || $past(wr_cfg))
    else $error("conversion count beyond sequence length");

  // A control write clears the complete flag unless a sequence ends.
  a_flag_clear: assert property (
    wr_ctl && !last_conv |=> !SEQ_DONE_O)
    else $error("complete flag not cleared by control write");

  // The control register reads back what was written.
  a_read_back: assert property (
    REG_RD_I && REG_ADDR_I == `CSC_OFS_CTL
    |=> REG_RDATA_O == {1'b0, $past(ctl_ff)})
    else $error("control register read back mismatch");

  // Read data stand one cycle only and are zero otherwise.
  a_read_idle: assert property (
    !REG_RD_I |=> REG_RDATA_O == 8'h00)
    else $error("read data outside the read answer cycle");

  // External select codes past the last input all land on input 5.
  a_ext_map: assert property (
    SAMPLE_START_O && !sc
    |-> CHAN_O.src == SRC_EXT &&
        CHAN_O.idx == ((code_ff > `CSC_LAST_EXT) ? 3'h5 : code_ff[2:0]))
    else $error("external channel decode mismatch");

  // The channel stands from the sample start through its conversion.
  a_chan_held: assert property (
    SEQ_BUSY_O && !conv_evt && !REG_WR_I |=> $stable(CHAN_O))
    else $error("channel changed inside a conversion");

  // An armed sequencer waits for a trigger or a register write.
  a_armed_wait: assert property (
    state_ff == ST_ARMED && !trig_rise && !REG_WR_I
    |=> state_ff == ST_ARMED)
    else $error("armed sequencer left without a trigger");

  // A finished single sequence stays idle until software writes.
  a_idle_quiet: assert property (
    state_ff == ST_IDLE && !REG_WR_I |=> !SAMPLE_START_O)
    else $error("idle sequencer started on its own");

  c_multi_wrap: cover property (conv_evt && multi_channel_mode && code_ff == wrap_ff);
  c_special:    cover property (SAMPLE_START_O && sc);
  c_scan_again: cover property (last_conv && scan_eff ##1 SAMPLE_START_O);
  c_trig_seq:   cover property (state_ff == ST_ARMED && trig_rise);
  c_abort:      cover property (wr_ctl && SEQ_BUSY_O);

endmodule

// >>> tb/csc_top_tb.sv
// Purpose: Self-checking bench for the conversion start control block.
// Assumes: Bench drives the register port, trigger pin and converter done.
// Notes:   Expected channels and read data queue up; a monitor compares.
`timescale 1ns/1ns
`include "csc_regs.svh"
module csc_top_tb
  import csc_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------------
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [7:0]  wdata    = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        trig     = 1'b0;
  logic        done     = 1'b0;
  logic [7:0]  rdata;
  logic        start;
  csc_chan_s   chan;
  logic        busy;
  logic        seq_done;
  logic        rd_seen  = 1'b0;
  logic [11:0] ch_q[$];
  logic [7:0]  rd_q[$];
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed       = 32'hd214e230;

  // Free-running bus clock at 125 MHz.
  always #4 clk = ~clk;

  csc_top csc_top_inst (
    .CLOCK_I        (clk),
    .RST_N_I        (rst_n),
    .REG_ADDR_I     (addr),
    .REG_WDATA_I    (wdata),
    .REG_WR_I       (wr),
    .REG_RD_I       (rd),
    .REG_RDATA_O    (rdata),
    .EXT_TRIG_I     (trig),
    .CONV_DONE_I    (done),
    .SAMPLE_START_O (start),
    .CHAN_O         (chan),
    .SEQ_BUSY_O     (busy),
    .SEQ_DONE_O     (seq_done)
  );

  // ----------------------------------------------------------------------
  // Comparison, verdict and expectation helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Expected channel plus a care mask; reference sources carry no index.
  function automatic logic [11:0] exp_chan(input logic sc,
                                           input logic [3:0] c);
    csc_chan_s  v;
    logic [5:0] m;
    m     = 6'h3f;
    v.src = SRC_EXT;
    v.idx = (c < 4'h5) ? c[2:0] : 3'h5;
    if (sc) begin
      v.idx = 3'h0;
      case (c)
        4'h0: begin v.src = SRC_INT; v.idx = 3'h6; end
        4'h1: begin v.src = SRC_INT; v.idx = 3'h7; end
        4'h2: begin v.src = SRC_INT; v.idx = 3'h0; end
        4'h3: begin v.src = SRC_INT; v.idx = 3'h1; end
        4'h4: begin v.src = SRC_VRH; m = 6'h38; end
        4'h5: begin v.src = SRC_VRL; m = 6'h38; end
        4'h6: begin v.src = SRC_MID; m = 6'h38; end
        4'h8, 4'h9, 4'ha, 4'hb: begin
          v.src = SRC_INT;
          v.idx = 3'(c - 4'h6);
        end
        default: begin v.src = SRC_RSVD; m = 6'h38; end
      endcase
    end
    return {v, m};
  endfunction

  // ----------------------------------------------------------------------
  // Monitor: read data one cycle after the strobe, channel at each start
  // ----------------------------------------------------------------------
  // Reads happen in the active region, so they see pre-edge values.
  always @(posedge clk) begin
    logic [11:0] e;
    if (rd_seen) begin
      check(rdata, rd_q.pop_front());
    end
    rd_seen = rd;
    if (start === 1'b1) begin
      if (ch_q.size() == 0) begin
        fail_count++;
        $display("ERROR at %0t: unexpected start", $time);
      end else begin
        e = ch_q.pop_front();
        check({2'b00, 6'(chan) & e[5:0]}, {2'b00, e[11:6] & e[5:0]});
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus and converter tasks
  // ----------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  // Bounded wait: a start that never comes ends the run as a failure.
  task automatic wait_start;
    int i;
    i = 0;
    @(posedge clk);
    while (start !== 1'b1) begin
      i++;
      if (i > 40) begin
        fail_count++;
        $display("ERROR at %0t: no start seen", $time);
        finish_test();
      end
      @(posedge clk);
    end
  endtask

  // Each start is answered by one done pulse in the convert cycle.
  task automatic run_seq(input int n);
    repeat (n) begin
      wait_start();
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
    end
  endtask

  task automatic end_chk;
    @(posedge clk);
    check({7'h00, seq_done}, 8'h01);
    check({7'h00, busy}, 8'h00);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int         k;
    int         j;
    int         n;
    logic [3:0] w;
    logic [3:0] c;
    logic [3:0] l;
    logic [3:0] s;
    logic [7:0] v;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`CSC_OFS_CTL, 8'h00);
    rd_reg(`CSC_OFS_WRAP, 8'h0f);
    rd_reg(8'h3c, 8'h00);
    $display("test reset_values done");
    // Every select code in both modes, with a one-conversion sequence.
    wr_reg(`CSC_OFS_CFG, 8'h01);
    for (k = 0; k < 32; k++) begin
      v = {k[0], k[4], 2'b00, k[3:0]};
      ch_q.push_back(exp_chan(k[4], k[3:0]));
      wr_reg(`CSC_OFS_CTL, v);
      run_seq(1);
      end_chk();
      rd_reg(`CSC_OFS_CTL, {1'b0, v[6:0]});
    end
    $display("test channel_map done");
    // Multi-channel sequences over length codes 0 to 6 and 15; first one wraps high.
    for (k = 0; k < 8; k++) begin
      w = 4'($unsigned($random(seed)) % 6);
      c = 4'($unsigned($random(seed)) % 8);
      l = (k == 7) ? 4'hf : 4'(k);
      if (k == 0) begin
        w = 4'h3;
        c = 4'h4;
      end
      s = c;
      n = (l >= 4'h1 && l <= 4'h5) ? int'(l) : 6;
      for (j = 0; j < n; j++) begin
        ch_q.push_back(exp_chan(1'b0, c));
        c = (c == w || c >= 4'h5) ? 4'h0 : c + 4'h1;
      end
      wr_reg(`CSC_OFS_WRAP, {4'h0, w});
      wr_reg(`CSC_OFS_CFG, {4'h0, l});
      wr_reg(`CSC_OFS_CTL, {4'h1, s});
      run_seq(n);
      end_chk();
    end
    $display("test multi_channel done");
    // Repeat mode restarts on its own; a control write aborts it.
    wr_reg(`CSC_OFS_CFG, 8'h01);
    repeat (3) ch_q.push_back(exp_chan(1'b0, 4'h2));
    wr_reg(`CSC_OFS_CTL, 8'h22);
    run_seq(2);
    wait_start();
    check({7'h00, seq_done}, 8'h01);
    ch_q.push_back(exp_chan(1'b0, 4'h1));
    wr_reg(`CSC_OFS_CTL, 8'h01);
    wait_start();
    check({7'h00, seq_done}, 8'h00);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    end_chk();
    repeat (10) @(posedge clk);
    $display("test repeat_abort done");
    // Trigger mode: the write only arms, each rise starts one sequence.
    wr_reg(`CSC_OFS_CFG, 8'h11);
    wr_reg(`CSC_OFS_CTL, 8'h23);
    repeat (10) @(posedge clk);
    for (k = 0; k < 2; k++) begin
      ch_q.push_back(exp_chan(1'b0, 4'h3));
      trig <= 1'b1;
      run_seq(1);
      end_chk();
      trig <= 1'b0;
      repeat (12) @(posedge clk);
    end
    check({7'h00, ch_q.size() == 0}, 8'h01);
    $display("test trigger done");
    // Status shows the flag; writing one to it clears the flag alone.
    rd_reg(`CSC_OFS_STAT, 8'h80);
    wr_reg(`CSC_OFS_STAT, 8'h80);
    rd_reg(`CSC_OFS_STAT, 8'h00);
    repeat (2) @(posedge clk);
    $display("test status_clear done");
    finish_test();
  end
endmodule
